// [dmairq_pkg.sv]
// Behaviour
// R1: eight enable bits in bits 23:16 of the channel interrupt control register, one enables each interrupt.
// R2: bits 31:24 and 15:8 of the channel interrupt control register read zero and ignore writes.
// R3: the source done flag sets when the source pointer becomes equal to the source size.
// R4: the source half flag sets when the source pointer becomes equal to half the source size.
// R5: the destination done flag sets when the destination pointer becomes equal to the destination size.
// R6: the source start register is a full 32-bit read/write register that resets to zero.
// R7: software must load the source start register with a physical address.
// R8: the interrupt output is high while any flag is set together with its enable.
package dmairq_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SRC_START = 4'h4;
  // ==========================================
  // fields of the interrupt control register
  localparam int EN_LSB = 16;
  localparam int FLAG_LSB = 0;
  localparam int BIT_SRC_DONE = 7;
  localparam int BIT_SRC_HALF = 6;
  localparam int BIT_DST_DONE = 5;
  localparam int BIT_DST_HALF = 4;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [31:0] SRC_START_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef struct packed {
    logic [15:0] source_pointer;
    logic [15:0] source_size;
    logic [15:0] dest_pointer;
    logic [15:0] dest_size;
  } dmairq_ptr_t;

  typedef enum logic [1:0] {
    DMAIRQ_IDLE,
    DMAIRQ_ANSWER
  } dmairq_state_t;
endpackage

// [dmairq_channel.sv]
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module dmairq_channel import dmairq_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire dmairq_ptr_t i_ptr,
  input wire logic [3:0] i_other_events,
  output logic [31:0] o_source_start_address,
  output logic o_irq
);
  // ==========================================
  // state
  dmairq_state_t state, next_state;
  logic [7:0] irq_en, next_irq_en;
  logic [7:0] irq_flag, next_irq_flag;
  logic [31:0] source_start_address, next_source_start_address;
  logic [31:0] readdata, next_readdata;
  dmairq_ptr_t ptr_q;
  logic [7:0] events;

  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // events fire on the cycle a pointer becomes equal, not while it stays equal
  always_comb begin
    events = {4'h0, i_other_events};
    events[BIT_SRC_DONE] = (i_ptr.source_pointer == i_ptr.source_size) &&
      (ptr_q.source_pointer != ptr_q.source_size); // see R3
    events[BIT_SRC_HALF] = (i_ptr.source_pointer == {1'b0, i_ptr.source_size[15:1]}) &&
      (ptr_q.source_pointer != {1'b0, ptr_q.source_size[15:1]}); // see R4
    events[BIT_DST_DONE] = (i_ptr.dest_pointer == i_ptr.dest_size) &&
      (ptr_q.dest_pointer != ptr_q.dest_size); // see R5
  end

  // writes commit on the answer edge, the only edge at which the master sees waitrequest low
  wire logic wr_hit = (state == DMAIRQ_ANSWER) && i_write;
  // reads are captured on the taking edge so the data already stands at the answer edge
  wire logic rd_hit = (state == DMAIRQ_IDLE) && i_read;

  // ==========================================
  // register file next values; one wait cycle then answer
  always_comb begin
    next_state = state;
    next_irq_en = irq_en;
    next_irq_flag = irq_flag;
    next_source_start_address = source_start_address;
    next_readdata = readdata;
    case (state)
      DMAIRQ_IDLE: begin
        if (i_read || i_write) begin
          next_state = DMAIRQ_ANSWER;
        end
      end
      DMAIRQ_ANSWER: begin
        next_state = DMAIRQ_IDLE;
      end
      default: begin
        next_state = DMAIRQ_IDLE;
      end
    endcase
    if (wr_hit && i_address == ADDR_IRQ_CTRL) begin
      // bytes 3 and 1 are unimplemented, writes there are dropped
      if (i_byteenable[2]) begin
        next_irq_en = i_writedata[EN_LSB +: 8]; // see R1, R2
      end
      if (i_byteenable[0]) begin
        next_irq_flag = irq_flag & ~i_writedata[FLAG_LSB +: 8];
      end
    end
    if (wr_hit && i_address == ADDR_SRC_START) begin
      next_source_start_address = merge_bytes(source_start_address, i_writedata, i_byteenable); // see R6
    end
    // set wins over a simultaneous write-one clear
    next_irq_flag = next_irq_flag | events;
    if (rd_hit) begin
      case (i_address)
        ADDR_IRQ_CTRL: next_readdata = {8'h00, irq_en, 8'h00, irq_flag}; // see R2
        ADDR_SRC_START: next_readdata = source_start_address;
        default: next_readdata = UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= DMAIRQ_IDLE;
      irq_en <= EN_RESET;
      irq_flag <= FLAG_RESET;
      source_start_address <= SRC_START_RESET; // see R6
      readdata <= 32'h00000000;
      // track the live pointers so that leaving reset never looks like a fresh match
      ptr_q <= i_ptr;
    end else if (i_ce) begin
      state <= next_state;
      irq_en <= next_irq_en;
      irq_flag <= next_irq_flag;
      source_start_address <= next_source_start_address;
      readdata <= next_readdata;
      ptr_q <= i_ptr;
    end
  end

  // software is trusted to have written a physical address (see R7)
  assign o_source_start_address = source_start_address;
  assign o_readdata = readdata;
  assign o_waitrequest = (state == DMAIRQ_IDLE);
  assign o_irq = |(irq_flag & irq_en); // see R8

  // ==========================================
  // checks
  property p_irq_level;
    @(posedge i_clk) disable iff (i_rst) o_irq == |(irq_flag & irq_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // see R8

  property p_src_done;
    @(posedge i_clk) disable iff (i_rst) (i_ce && events[BIT_SRC_DONE]) |=> irq_flag[BIT_SRC_DONE];
  endproperty
  a_src_done: assert property (p_src_done) else $error("source done not set"); // see R3

  property p_src_half;
    @(posedge i_clk) disable iff (i_rst) (i_ce && events[BIT_SRC_HALF]) |=> irq_flag[BIT_SRC_HALF];
  endproperty
  a_src_half: assert property (p_src_half) else $error("source half not set"); // see R4

  property p_dst_done;
    @(posedge i_clk) disable iff (i_rst) (i_ce && events[BIT_DST_DONE]) |=> irq_flag[BIT_DST_DONE];
  endproperty
  a_dst_done: assert property (p_dst_done) else $error("dest done not set"); // see R5

  sequence s_rd_ctrl;
    rd_hit && i_ce && i_address == ADDR_IRQ_CTRL;
  endsequence
  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_rst) s_rd_ctrl |=> (o_readdata[31:24] == 8'h00 && o_readdata[15:8] == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // see R2

  property p_en_write;
    @(posedge i_clk) disable iff (i_rst)
      (wr_hit && i_ce && i_address == ADDR_IRQ_CTRL && i_byteenable[2]) |=> irq_en == $past(i_writedata[23:16]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost"); // see R1

  property p_ssa_write;
    @(posedge i_clk) disable iff (i_rst)
      (wr_hit && i_ce && i_address == ADDR_SRC_START && i_byteenable == 4'hf) |=> source_start_address == $past(i_writedata);
  endproperty
  a_ssa_write: assert property (p_ssa_write) else $error("source start write lost"); // see R6

  property p_ssa_reset;
    @(posedge i_clk) $past(i_rst) |-> source_start_address == SRC_START_RESET;
  endproperty
  a_ssa_reset: assert property (p_ssa_reset) else $error("source start not reset"); // see R6

  // ==========================================
  // bus handshake, freeze and flag history checks
  // building blocks shared by the properties below
  sequence s_taken;
    i_ce && state == DMAIRQ_IDLE && (i_read || i_write);
  endsequence
  sequence s_answer;
    i_ce && state == DMAIRQ_ANSWER;
  endsequence
  sequence s_ctrl_wr;
    wr_hit && i_ce && i_address == ADDR_IRQ_CTRL;
  endsequence
  sequence s_frozen;
    !i_ce;
  endsequence

  // a taken request is answered on the very next cycle
  property p_wait_after_take;
    @(posedge i_clk) disable iff (i_rst) s_taken |=> !o_waitrequest;
  endproperty
  a_wait_after_take: assert property (p_wait_after_take) else $error("request not answered");

  // the answer lasts one cycle only; a strobe still held after it is taken again from idle
  property p_wait_one;
    @(posedge i_clk) disable iff (i_rst) s_answer |=> o_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");

  // idle always stalls the master
  property p_wait_idle;
    @(posedge i_clk) disable iff (i_rst) state == DMAIRQ_IDLE |-> o_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low in idle");

  // read data stands until the next taken read
  property p_rd_stand;
    @(posedge i_clk) disable iff (i_rst) (!rd_hit || !i_ce) |=> $stable(o_readdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");

  // a low clock enable freezes the flags, even with events arriving
  property p_freeze_flag;
    @(posedge i_clk) disable iff (i_rst) s_frozen |=> $stable(irq_flag);
  endproperty
  a_freeze_flag: assert property (p_freeze_flag) else $error("flags moved while frozen");

  // a low clock enable freezes the writable registers
  property p_freeze_regs;
    @(posedge i_clk) disable iff (i_rst) s_frozen |=> $stable(irq_en) && $stable(source_start_address);
  endproperty
  a_freeze_regs: assert property (p_freeze_regs) else $error("registers moved while frozen"); // see R1, R6

  // a low clock enable stalls the bus answer as well
  property p_freeze_state;
    @(posedge i_clk) disable iff (i_rst) s_frozen |=> $stable(state);
  endproperty
  a_freeze_state: assert property (p_freeze_state) else $error("bus state moved while frozen");

  // the source done flag is sticky until software writes a one to it
  property p_src_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (irq_flag[BIT_SRC_DONE] && !(wr_hit && i_address == ADDR_IRQ_CTRL && i_byteenable[0] &&
      i_writedata[BIT_SRC_DONE])) |=> irq_flag[BIT_SRC_DONE];
  endproperty
  a_src_sticky: assert property (p_src_sticky) else $error("source done flag lost"); // see R3

  // write-one clears the source done flag when no new match arrives with it
  property p_src_clear;
    @(posedge i_clk) disable iff (i_rst)
      s_ctrl_wr ##0 (i_byteenable[0] && i_writedata[BIT_SRC_DONE] && !events[BIT_SRC_DONE]) |=> !irq_flag[BIT_SRC_DONE];
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("source done flag not cleared"); // see R3

  // write-one clears the destination done flag when no new match arrives with it
  property p_dst_clear;
    @(posedge i_clk) disable iff (i_rst)
      s_ctrl_wr ##0 (i_byteenable[0] && i_writedata[BIT_DST_DONE] && !events[BIT_DST_DONE]) |=> !irq_flag[BIT_DST_DONE];
  endproperty
  a_dst_clear: assert property (p_dst_clear) else $error("dest done flag not cleared"); // see R5

  // a control write without the enable lane leaves the enables alone
  property p_en_keep;
    @(posedge i_clk) disable iff (i_rst) s_ctrl_wr ##0 !i_byteenable[2] |=> $stable(irq_en);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enables changed by other lanes"); // see R1, R2

  // pulses on the other event inputs land in the low flags
  property p_other_set;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && |i_other_events) |=> (irq_flag[3:0] & $past(i_other_events)) == $past(i_other_events);
  endproperty
  a_other_set: assert property (p_other_set) else $error("other event flag not set");

  // without a match and while running, a clear source done flag stays clear
  property p_src_quiet;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !irq_flag[BIT_SRC_DONE] && !events[BIT_SRC_DONE]) |=> !irq_flag[BIT_SRC_DONE];
  endproperty
  a_src_quiet: assert property (p_src_quiet) else $error("source done flag set without match"); // see R3

  // the source done flag only rises after the pointer met the size
  property p_src_done_match;
    @(posedge i_clk) disable iff (i_rst)
      $rose(irq_flag[BIT_SRC_DONE]) |-> $past(i_ptr.source_pointer) == $past(i_ptr.source_size);
  endproperty
  a_src_done_match: assert property (p_src_done_match) else $error("source done rose early"); // see R3

  // the half flag only rises after the pointer met the midpoint
  property p_half_match;
    @(posedge i_clk) disable iff (i_rst)
      $rose(irq_flag[BIT_SRC_HALF]) |-> $past(i_ptr.source_pointer) == {1'b0, $past(i_ptr.source_size[15:1])};
  endproperty
  a_half_match: assert property (p_half_match) else $error("source half rose early"); // see R4

  // the destination done flag only rises after the pointer met the size
  property p_dst_done_match;
    @(posedge i_clk) disable iff (i_rst)
      $rose(irq_flag[BIT_DST_DONE]) |-> $past(i_ptr.dest_pointer) == $past(i_ptr.dest_size);
  endproperty
  a_dst_done_match: assert property (p_dst_done_match) else $error("dest done rose early"); // see R5

  // the source start register only changes by a write to its own address
  property p_ssa_keep;
    @(posedge i_clk) disable iff (i_rst)
      !(wr_hit && i_ce && i_address == ADDR_SRC_START) |=> $stable(source_start_address);
  endproperty
  a_ssa_keep: assert property (p_ssa_keep) else $error("source start changed"); // see R6

  // the register value is what the transfer engine sees
  property p_ssa_port;
    @(posedge i_clk) disable iff (i_rst) o_source_start_address == source_start_address;
  endproperty
  a_ssa_port: assert property (p_ssa_port) else $error("source start port differs"); // see R6

  // holes in the map read as zero
  property p_unmapped;
    @(posedge i_clk) disable iff (i_rst)
      (rd_hit && i_ce && i_address != ADDR_IRQ_CTRL && i_address != ADDR_SRC_START) |=> o_readdata == UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // a masked flag never raises the request
  property p_irq_masked;
    @(posedge i_clk) disable iff (i_rst) (irq_en == 8'h00) |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("request with all enables off"); // see R8
endmodule

// [dmairq_channel_tb.sv]
`timescale 1ns/1ps
module dmairq_channel_tb import dmairq_pkg::*;;
  // ==========================================
  // stimulus table and bench signals
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} dmairq_row_t;
  localparam dmairq_row_t rows [5] = '{
    '{ADDR_IRQ_CTRL, 32'hffffff00, 4'hf, 32'h00ff0000},
    '{ADDR_IRQ_CTRL, 32'hff00ff00, 4'h4, 32'h00000000},
    '{ADDR_SRC_START, 32'hdeadbeef, 4'hf, 32'hdeadbeef},
    '{ADDR_SRC_START, 32'h11223344, 4'h4, 32'hde22beef},
    '{4'h8, 32'hffffffff, 4'hf, 32'h00000000}};
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0, wt, irq;
  logic [3:0] adr = 4'h0, be = 4'hf, ev = 4'h0;
  logic [31:0] wd = 32'h0, rdat, ssa, q;
  // sizes are nonzero from time zero so no flag sets before the pointers move
  dmairq_ptr_t ptr = {16'h0000, 16'h0010, 16'h0000, 16'h0020};
  int n_fail = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  dmairq_channel uut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wt), .i_ptr(ptr),
    .i_other_events(ev), .o_source_start_address(ssa), .o_irq(irq));
  // ==========================================
  // compare, bus and closing tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; data is taken at that edge only
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(n, e, q);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("ctrl_reset", ADDR_IRQ_CTRL, 32'h0);
    rchk("src_reset", ADDR_SRC_START, SRC_START_RESET);
    chk("irq_reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    // register rows: lane masks and reserved bytes included
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
      rchk("row_readback", rows[i].a, rows[i].e);
    end
    chk("src_port", 32'hde22beef, ssa);
    $display("test registers done");
    bus(1'b1, ADDR_IRQ_CTRL, 32'h00e00000, 4'hf);
    ptr.source_pointer <= 16'h0008;
    repeat (3) @(posedge clk);
    rchk("half_flag", ADDR_IRQ_CTRL, 32'h00e00040);
    @(negedge clk);
    chk("irq_half", 32'h1, {31'h0, irq});
    bus(1'b1, ADDR_IRQ_CTRL, 32'h00e00040, 4'hf);
    @(negedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    ptr.source_pointer <= 16'h0010;
    ptr.dest_pointer <= 16'h0020;
    repeat (3) @(posedge clk);
    rchk("done_flags", ADDR_IRQ_CTRL, 32'h00e000a0);
    // masking keeps the flags but must drop the request
    bus(1'b1, ADDR_IRQ_CTRL, 32'h00000000, 4'hf);
    @(negedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("masked_flags", ADDR_IRQ_CTRL, 32'h000000a0);
    // pointers still equal: a cleared flag must not come back without a new match
    bus(1'b1, ADDR_IRQ_CTRL, 32'h000000ff, 4'hf);
    repeat (3) @(posedge clk);
    rchk("flags_stay_clear", ADDR_IRQ_CTRL, 32'h0);
    // other event inputs set the low flags; nothing lands while the clock enable is low
    bus(1'b1, ADDR_IRQ_CTRL, 32'h000f0000, 4'hf);
    ev <= 4'h5;
    @(posedge clk);
    ev <= 4'h0;
    ce <= 1'b0;
    @(posedge clk);
    ev <= 4'h2;
    @(posedge clk);
    ev <= 4'h0;
    ce <= 1'b1;
    rchk("other_flags", ADDR_IRQ_CTRL, 32'h000f0005);
    @(negedge clk);
    chk("irq_other", 32'h1, {31'h0, irq});
    $display("test interrupts done");
    // second reset in mid-run with pointers sitting on their ends
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("wait_reset", 32'h1, {31'h0, wt});
    rchk("ctrl_rerst", ADDR_IRQ_CTRL, 32'h0);
    rchk("src_rerst", ADDR_SRC_START, SRC_START_RESET);
    chk("irq_rerst", 32'h0, {31'h0, irq});
    $display("test mid reset done");
    test_done();
  end
  // watchdog: the whole run takes well under 300 cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
